// ==== apm_device_end.sv ====
// Function
// - Digital supply cycling resets; analog supplies do not
// - Raise ready after reset; convert if start high
// - Power-on flag sets on reset, write-one clears
// - Any analog monitor low sets sticky flag
// - Digital supply loss also sets analog flag
// - Common-mode output follows its enable bit
// - Speed bit selects high or low clock
// - Idle keeps sampling, stops only filter
// - Standby bit stops sampling while conversions stopped
// - Leaving standby adds 24 cycles to latency
// - Power-down stops everything but serial port, registers, common-mode output
// - Writing zero or any reset leaves power-down
// - Any reset restarts logic and restores registers
// - Reset pin low then high resets device
// - Writing code 58h to control register resets
// - Four-wire resets at chip select, three-wire last edge
// - Host uses write reset only when aligned
// - Zero after 1023 ones resets on falling edge
// - Four-wire: 1024 ones then chip select resets
// - Daisy chains use the ones-then-select pattern
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ns
module apm_device_end
	import apm_pkg::*;
	#(
	parameter int CONV_HS_CYCLES = CONV_HS,
	parameter int CONV_LS_CYCLES = CONV_LS
	)
	(
	input wire logic aclk,
	input wire logic aresetn,
	apm_link_if.dev link,
	input wire logic digital_io_supply_ok,
	input wire logic [3:0] analog_supply_ok,
	output logic common_mode_output,
	output logic sampling_active,
	output logic filter_active,
	output logic analog_powered,
	output logic speed_high
	);
	typedef struct packed {
		logic [PIN_W-1:0] sy1;
		logic [PIN_W-1:0] sy2;
		logic sclk_d;
		logic cs_d;
	} apm_dev_io_t;
	typedef struct packed {
		logic por_flag;
		logic analog_low_voltage_flag;
		logic [7:0] cfg_one;
		logic [7:0] cfg_two;
		logic [15:0] shift;
		logic [4:0] bits;
		logic rd_mode;
		logic [7:0] rd_data;
		logic reset_at_cs;
		logic sdo;
		logic sdo_oe;
		logic [3:0] init_cnt;
		logic ready;
		logic converting;
		logic standby;
		logic [9:0] cnv_cnt;
		logic [2:0] low_cnt;
		logic conversion_ready_n_n;
		logic cm_out;
		logic sampling;
		logic filter_on;
		logic powered;
		logic speed;
	} apm_dev_core_t;
	typedef struct packed {
		apm_dev_io_t io;
		apm_dev_core_t c;
	} apm_dev_state_t;
	// Both flags come up set at aresetn; por_flag makes every reset, whatever its source, visible afterwards
	localparam apm_dev_core_t CORE_RST = '{default: '0, por_flag: 1'b1, analog_low_voltage_flag: 1'b1,
		cfg_one: CFG_ONE_RST, cfg_two: CFG_TWO_RST};
	// Synchronisers start at the idle pin levels so no false chip-select edge follows reset
	localparam logic [PIN_W-1:0] PINS_IDLE = 10'h3ea;
	localparam apm_dev_io_t IO_RST = '{sy1: PINS_IDLE, sy2: PINS_IDLE, sclk_d: 1'b0,
		cs_d: 1'b1};
	apm_dev_state_t s;
	apm_dev_state_t next_s;
	logic [PIN_W-1:0] pins;
	logic sclk_fall;
	logic sclk_rise;
	logic cs_rise;
	logic three_w;
	logic sel;
	logic shift_en;
	logic wr_rst;
	logic pat_rst;
	logic dev_rst;
	logic alv_evt;
	logic pd;
	logic run;
	logic [9:0] period;
	logic [15:0] frame;
	logic [7:0] rd_val;
	logic ones_zero;
	logic ones_cs;

	assign pins = {analog_supply_ok, digital_io_supply_ok, link.start, link.reset_n,
		link.sdi, link.cs_n, link.sclk};
	assign link.sdo = s.c.sdo;
	assign link.sdo_oe = s.c.sdo_oe;
	assign link.conversion_ready_n = s.c.conversion_ready_n_n;
	assign common_mode_output = s.c.cm_out;
	assign sampling_active = s.c.sampling;
	assign filter_active = s.c.filter_on;
	assign analog_powered = s.c.powered;
	assign speed_high = s.c.speed;

	apm_ones_counter u_ones (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(dev_rst),
		.shift_en(shift_en),
		.bit_in(s.io.sy2[P_SDI]),
		.ge_zero_run(ones_zero),
		.ge_cs_run(ones_cs)
	);

	always_comb
	begin
		next_s = s;
		wr_rst = 1'b0;
		pat_rst = 1'b0;
		next_s.io.sy1 = pins;
		next_s.io.sy2 = s.io.sy1;
		next_s.io.sclk_d = s.io.sy2[P_SCLK];
		next_s.io.cs_d = s.io.sy2[P_CS];
		three_w = s.c.cfg_one[C1_3W];
		sclk_fall = s.io.sclk_d && !s.io.sy2[P_SCLK];
		sclk_rise = !s.io.sclk_d && s.io.sy2[P_SCLK];
		cs_rise = !s.io.cs_d && s.io.sy2[P_CS] && !three_w;
		// Three-wire has no framing pin, so every clock edge belongs to a frame
		sel = three_w || !s.io.sy2[P_CS];
		shift_en = sel && sclk_fall;
		frame = {s.c.shift[14:0], s.io.sy2[P_SDI]};
		alv_evt = !(&s.io.sy2[P_ANA +: 4]);
		pd = s.c.cfg_two[C2_PDN];
		period = s.c.cfg_two[C2_SPEED] ? 10'(CONV_HS_CYCLES) : 10'(CONV_LS_CYCLES);
		run = s.c.ready && !pd && s.io.sy2[P_START];
		rd_val = 8'h00;
		case (frame[6:0])
			ADDR_STATUS:
			begin
				rd_val[ST_POR] = s.c.por_flag;
				rd_val[ST_ALV] = s.c.analog_low_voltage_flag;
				rd_val[ST_PDN] = pd;
				rd_val[ST_STBY] = s.c.standby;
				rd_val[ST_RDY] = s.c.ready;
			end
			ADDR_CFG_ONE:
				rd_val = s.c.cfg_one;
			ADDR_CFG_TWO:
				rd_val = s.c.cfg_two;
			default:
				rd_val = 8'h00;
		endcase
		if (cs_rise)
		begin
			next_s.c.bits = 5'd0;
			next_s.c.rd_mode = 1'b0;
			next_s.c.sdo_oe = 1'b0;
			next_s.c.reset_at_cs = 1'b0;
			wr_rst = s.c.reset_at_cs;
			pat_rst = ones_cs;
		end
		if (shift_en)
		begin
			next_s.c.shift = frame;
			next_s.c.bits = s.c.bits + 5'd1;
			if (!s.io.sy2[P_SDI] && ones_zero)
				pat_rst = 1'b1;
			if (s.c.bits == 5'd7)
			begin
				next_s.c.rd_mode = frame[7];
				next_s.c.rd_data = rd_val;
			end
			if (s.c.bits == 5'(FRAME_BITS - 1))
			begin
				next_s.c.bits = 5'd0;
				next_s.c.rd_mode = 1'b0;
				if (!s.c.rd_mode)
				begin
					case (frame[14:8])
						ADDR_STATUS:
						begin
							if (frame[ST_POR])
								next_s.c.por_flag = 1'b0;
							if (frame[ST_ALV])
								next_s.c.analog_low_voltage_flag = 1'b0;
						end
						ADDR_CONTROL:
							if (frame[7:0] == RESET_CODE)
							begin
								if (three_w)
									wr_rst = 1'b1;
								else
									next_s.c.reset_at_cs = 1'b1;
							end
						ADDR_CFG_ONE:
							next_s.c.cfg_one = frame[7:0];
						ADDR_CFG_TWO:
							next_s.c.cfg_two = frame[7:0];
						default:
							next_s.c.rd_mode = 1'b0;
					endcase
				end
			end
		end
		// Data bits leave on rising edges so the host sees them settled at the next one
		if (sel && sclk_rise)
		begin
			if (s.c.rd_mode && s.c.bits >= 5'd8)
			begin
				next_s.c.sdo = s.c.rd_data[7];
				next_s.c.rd_data = {s.c.rd_data[6:0], 1'b0};
				next_s.c.sdo_oe = 1'b1;
			end
			else
				next_s.c.sdo_oe = 1'b0;
		end
		if (alv_evt)
			next_s.c.analog_low_voltage_flag = 1'b1;
		if (s.c.low_cnt != 3'd0)
		begin
			next_s.c.low_cnt = s.c.low_cnt - 3'd1;
			if (s.c.low_cnt == 3'd1)
				next_s.c.conversion_ready_n_n = 1'b1;
		end
		if (!s.c.ready)
		begin
			if (s.c.init_cnt == 4'(INIT_CYCLES - 1))
			begin
				next_s.c.ready = 1'b1;
				next_s.c.conversion_ready_n_n = 1'b1;
			end
			else
				next_s.c.init_cnt = s.c.init_cnt + 4'd1;
		end
		else if (run && !s.c.converting)
		begin
			next_s.c.converting = 1'b1;
			next_s.c.cnv_cnt = period + (s.c.standby ? 10'(STANDBY_EXTRA) : 10'd0);
			next_s.c.conversion_ready_n_n = 1'b1;
			next_s.c.low_cnt = 3'd0;
		end
		else if (s.c.converting)
		begin
			if (!run)
				next_s.c.converting = 1'b0;
			else if (s.c.cnv_cnt == 10'd0)
			begin
				next_s.c.conversion_ready_n_n = 1'b0;
				next_s.c.low_cnt = 3'(CONVERSION_READY_N_LOW_CYCLES);
				next_s.c.cnv_cnt = period - 10'd1;
			end
			else
				next_s.c.cnv_cnt = s.c.cnv_cnt - 10'd1;
		end
		next_s.c.standby = !run && s.c.ready && s.c.cfg_two[C2_STBY];
		next_s.c.filter_on = next_s.c.converting;
		next_s.c.sampling = !pd && !next_s.c.standby;
		next_s.c.powered = !pd;
		next_s.c.cm_out = s.c.cfg_one[C1_CM];
		next_s.c.speed = s.c.cfg_two[C2_SPEED];
		// Reset pin is held low as a level: the device stays reset until it rises
		dev_rst = !s.io.sy2[P_RST] || !s.io.sy2[P_DIO] || wr_rst || pat_rst;
		if (dev_rst)
		begin
			next_s.c = CORE_RST;
			next_s.c.analog_low_voltage_flag = s.c.analog_low_voltage_flag || alv_evt || !s.io.sy2[P_DIO];
		end
	end

	// Analog monitors only raise the flag; they never reach the reset path
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= '{io: IO_RST, c: CORE_RST};
		else
			s <= next_s;
	end
endmodule

// ==== apm_pkg.sv ====
package apm_pkg;
	localparam logic [6:0] ADDR_STATUS = 7'h01;
	localparam logic [6:0] ADDR_CONTROL = 7'h04;
	localparam logic [6:0] ADDR_CFG_ONE = 7'h05;
	localparam logic [6:0] ADDR_CFG_TWO = 7'h06;
	localparam logic [7:0] RESET_CODE = 8'h58;
	localparam logic [7:0] CFG_ONE_RST = 8'h00;
	localparam logic [7:0] CFG_TWO_RST = 8'h01;
	localparam int ST_POR = 0;
	localparam int ST_ALV = 1;
	localparam int ST_PDN = 2;
	localparam int ST_STBY = 3;
	localparam int ST_RDY = 4;
	localparam int C1_CM = 0;
	localparam int C1_3W = 1;
	localparam int C2_SPEED = 0;
	localparam int C2_STBY = 1;
	localparam int C2_PDN = 2;
	localparam int P_SCLK = 0;
	localparam int P_CS = 1;
	localparam int P_SDI = 2;
	localparam int P_RST = 3;
	localparam int P_START = 4;
	localparam int P_DIO = 5;
	localparam int P_ANA = 6;
	localparam int PIN_W = 10;
	localparam int FRAME_BITS = 16;
	localparam int PATTERN_ONE_ONES = 1023;
	localparam int PATTERN_TWO_ONES = 1024;
	localparam int PATTERN_BITS = 1024;
	localparam int ONES_W = 11;
	localparam int STANDBY_EXTRA = 24;
	localparam int INIT_CYCLES = 8;
	localparam int CONVERSION_READY_N_LOW_CYCLES = 4;
	localparam int CONV_HS = 64;
	localparam int CONV_LS = 512;
	localparam int CLK_PERIOD_NS = 100;
	localparam int SCLK_PERIOD_NS = 800;
	localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam logic [3:0] A_FRAME = 4'h0;
	localparam logic [3:0] A_PATTERN = 4'h4;
	localparam logic [3:0] A_PINS = 4'h8;
	localparam logic [3:0] A_STATUS = 4'hc;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== apm_link_if.sv ====
`timescale 1ns/1ns
interface apm_link_if;
	logic sclk;
	logic cs_n;
	logic sdi;
	logic sdo;
	logic sdo_oe;
	logic sdo_line;
	logic reset_n;
	logic start;
	logic conversion_ready_n;
	// Undriven data-out line floats high through the pull-up
	assign sdo_line = sdo_oe ? sdo : 1'b1;
	modport dev(input sclk, input cs_n, input sdi, input reset_n, input start,
		output sdo, output sdo_oe, output conversion_ready_n);
	modport host(output sclk, output cs_n, output sdi, output reset_n, output start,
		input sdo_line, input conversion_ready_n);
endinterface

// ==== apm_ones_counter.sv ====
`timescale 1ns/1ns
module apm_ones_counter
	import apm_pkg::*;
	#(
	parameter int W = ONES_W
	)
	(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clear,
	input wire logic shift_en,
	input wire logic bit_in,
	output logic ge_zero_run,
	output logic ge_cs_run
	);
	typedef struct packed {
		logic [W-1:0] cnt;
	} apm_cnt_state_t;
	apm_cnt_state_t s;
	apm_cnt_state_t next_s;

	assign ge_zero_run = s.cnt >= W'(PATTERN_ONE_ONES);
	assign ge_cs_run = s.cnt >= W'(PATTERN_TWO_ONES);

	always_comb
	begin
		next_s = s;
		if (clear)
			next_s.cnt = '0;
		else if (shift_en)
		begin
			if (!bit_in)
				next_s.cnt = '0;
			else if (!(&s.cnt))
				next_s.cnt = s.cnt + 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= '0;
		else
			s <= next_s;
	end
endmodule

// ==== apm_host_end.sv ====
`timescale 1ns/1ns
module apm_host_end
	import apm_pkg::*;
	(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	apm_link_if.host link
	);
	localparam logic [2:0] DIV_LAST = 3'(SCLK_HALF_CYCLES - 1);
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic aw_got;
		logic w_got;
		logic [3:0] aw_addr;
		logic [31:0] w_data;
		logic w_lane0;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [1:0] sy1;
		logic [1:0] sy2;
		logic busy;
		logic run;
		logic pat;
		logic p1;
		logic [15:0] tx;
		logic [7:0] rx;
		logic [11:0] ph;
		logic [11:0] nph;
		logic [2:0] div;
		logic sclk;
		logic cs_n;
		logic sdi;
		logic reset_n;
		logic start;
		logic three_w;
	} apm_host_state_t;
	localparam apm_host_state_t HOST_RST = '{default: '0, awready: 1'b1, wready: 1'b1,
		arready: 1'b1, cs_n: 1'b1, reset_n: 1'b1};
	apm_host_state_t s;
	apm_host_state_t next_s;
	logic tick;

	assign awready = s.awready;
	assign wready = s.wready;
	assign bresp = s.bresp;
	assign bvalid = s.bvalid;
	assign arready = s.arready;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign rvalid = s.rvalid;
	assign link.sclk = s.sclk;
	assign link.cs_n = s.cs_n;
	assign link.sdi = s.sdi;
	assign link.reset_n = s.reset_n;
	assign link.start = s.start;

	always_comb
	begin
		next_s = s;
		next_s.sy1 = {link.conversion_ready_n, link.sdo_line};
		next_s.sy2 = s.sy1;
		tick = s.div == DIV_LAST;
		next_s.div = tick ? 3'd0 : s.div + 3'd1;
		if (awvalid && s.awready)
		begin
			next_s.aw_got = 1'b1;
			next_s.aw_addr = awaddr;
		end
		if (wvalid && s.wready)
		begin
			next_s.w_got = 1'b1;
			next_s.w_data = wdata;
			next_s.w_lane0 = wstrb[0];
		end
		if (s.bvalid && bready)
			next_s.bvalid = 1'b0;
		if (s.aw_got && s.w_got && !s.bvalid)
		begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			case (s.aw_addr)
				A_FRAME:
					if (s.w_lane0 && !s.busy)
					begin
						next_s.busy = 1'b1;
						next_s.pat = 1'b0;
						next_s.tx = s.w_data[15:0];
						next_s.nph = 12'(2 * FRAME_BITS);
					end
				A_PATTERN:
					if (s.w_lane0 && !s.busy)
					begin
						next_s.busy = 1'b1;
						next_s.pat = 1'b1;
						next_s.p1 = s.w_data[0];
						next_s.nph = 12'(2 * PATTERN_BITS);
					end
				A_PINS:
					if (s.w_lane0)
					begin
						next_s.reset_n = !s.w_data[0];
						next_s.start = s.w_data[1];
						next_s.three_w = s.w_data[2];
					end
				A_STATUS:
					next_s.bresp = RESP_OKAY;
				default:
					next_s.bresp = RESP_SLVERR;
			endcase
		end
		next_s.awready = !next_s.aw_got && !next_s.bvalid;
		next_s.wready = !next_s.w_got && !next_s.bvalid;
		if (s.rvalid && rready)
			next_s.rvalid = 1'b0;
		if (arvalid && s.arready)
		begin
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			case (araddr)
				A_STATUS:
					next_s.rdata = {16'h0000, s.rx, 6'h00, s.sy2[1], s.busy};
				A_PINS:
					next_s.rdata = {29'h0, s.three_w, s.start, !s.reset_n};
				A_FRAME, A_PATTERN:
					next_s.rdata = 32'h0;
				default:
				begin
					next_s.rdata = 32'h0;
					next_s.rresp = RESP_SLVERR;
				end
			endcase
		end
		next_s.arready = !next_s.rvalid;
		// Jobs begin only on a tick so that chip select stays high a whole half period
		if (tick && s.busy)
		begin
			if (!s.run)
			begin
				next_s.run = 1'b1;
				next_s.ph = 12'd0;
			end
			else if (s.ph == s.nph)
			begin
				next_s.rx = {s.rx[6:0], s.sy2[0]};
				next_s.run = 1'b0;
				next_s.busy = 1'b0;
			end
			else if (!s.ph[0])
			begin
				next_s.sclk = 1'b1;
				if (s.ph != 12'd0)
					next_s.rx = {s.rx[6:0], s.sy2[0]};
				next_s.sdi = s.pat ? !(s.p1 && s.ph == s.nph - 12'd2) : s.tx[15];
				next_s.tx = {s.tx[14:0], 1'b0};
				next_s.ph = s.ph + 12'd1;
			end
			else
			begin
				next_s.sclk = 1'b0;
				next_s.ph = s.ph + 12'd1;
			end
		end
		next_s.cs_n = !(next_s.run || next_s.three_w);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= HOST_RST;
		else
			s <= next_s;
	end
endmodule

// ==== apm_sva.sv ====
`timescale 1ns/1ns
module apm_sva
	import apm_pkg::*;
	(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic reset_n,
	input wire logic start,
	input wire logic conversion_ready_n
	);
	logic [10:0] ones;
	logic [15:0] sh;
	// Ones run as the wire shows it, saturating at 1024 where the device counter runs to 2047
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !reset_n)
			ones <= 11'h0;
		else if ($fell(sclk))
			ones <= !sdi ? 11'h0 : ones + (ones != 11'h400);
		else if ($rose(cs_n) && ones == 11'h400)
			ones <= 11'h0;
		if (!aresetn)
			sh <= 16'h0;
		else if ($fell(sclk))
			sh <= {sh[14:0], sdi};
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	cs_idle_a: assert property (cs_n |-> !sclk)
		else $error("serial clock moves while deselected");
	sclk_half_a: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
		else $error("serial clock half period wrong");
	pin_reset_a: assert property ($fell(reset_n) |-> ##[1:5] !conversion_ready_n)
		else $error("reset pin ignored");
	ready_rise_a: assert property ($rose(reset_n) |-> ##[4:24] conversion_ready_n)
		else $error("ready not raised after reset");
	ready_pulse_a: assert property ($fell(conversion_ready_n) && reset_n
		|=> (!conversion_ready_n || !start)[*3])
		else $error("ready pulse too short");
	pattern_one_a: assert property ($fell(sclk) && !sdi && ones >= 11'h3ff
		|-> ##[1:6] !conversion_ready_n)
		else $error("ones then zero did not reset");
	pattern_two_a: assert property ($rose(cs_n) && ones == 11'h400
		|-> ##[1:6] !conversion_ready_n)
		else $error("ones then deselect did not reset");
	ctrl_reset_a: assert property ($rose(cs_n) && sh == {1'h0, ADDR_CONTROL, RESET_CODE}
		|-> ##[1:6] !conversion_ready_n)
		else $error("control write did not reset");
	cover property ($rose(cs_n) && ones == 11'h400);
	cover property ($fell(sclk) && !sdi && ones >= 11'h3ff);
	cover property ($fell(reset_n));
endmodule

// ==== tb_adc_power_mode_reset_ctrl.sv ====
`timescale 1ns/1ns
module tb_adc_power_mode_reset_ctrl
	import apm_pkg::*;
	();
	logic aclk = 1'h0, aresetn = 1'h0, dio_ok = 1'h1;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, ana_ok = 4'hf;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = 32'h0, rdata, d, k;
	logic awready, wready, bvalid, arready, rvalid, cm, samp, filt, pwr, spd;
	logic [1:0] bresp, rresp, r;
	int mismatches = 0, n_tests = 0, lat0, lat1, i;
	apm_link_if link ();
	apm_host_end u_apm_host_end (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .link(link));
	// Short conversion periods keep the latency scenarios quick
	apm_device_end #(.CONV_HS_CYCLES(8), .CONV_LS_CYCLES(16)) u_apm_device_end (.aclk(aclk),
		.aresetn(aresetn), .link(link), .digital_io_supply_ok(dio_ok), .analog_supply_ok(ana_ok),
		.common_mode_output(cm), .sampling_active(samp), .filter_active(filt),
		.analog_powered(pwr), .speed_high(spd));
	apm_sva u_apm_sva (.aclk(aclk), .aresetn(aresetn), .sclk(link.sclk), .cs_n(link.cs_n),
		.sdi(link.sdi), .reset_n(link.reset_n), .start(link.start),
		.conversion_ready_n(link.conversion_ready_n));
	initial
	begin
		forever #50 aclk = ~aclk;
	end
	task test_done;
		if (mismatches == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task tmo(input int n);
		if (n > 5000)
		begin
			mismatches++;
			$display("wrong value at %0t: wait timed out", $time);
			test_done();
		end
	endtask
	task axw(input logic [3:0] a, input logic [31:0] v);
		int n;
		logic ab, wb, bv;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hf;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		n = 0;
		// Handshakes are judged mid-cycle, away from the edge that updates them
		do
		begin
			@(negedge aclk);
			ab = awready && awvalid;
			wb = wready && wvalid;
			bv = bvalid;
			r = bresp;
			n++;
			tmo(n);
			@(posedge aclk);
			if (ab)
				awvalid <= 1'h0;
			if (wb)
				wvalid <= 1'h0;
		end while (!bv);
		bready <= 1'h0;
	endtask
	task axr(input logic [3:0] a);
		int n;
		logic ab, rv;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		n = 0;
		do
		begin
			@(negedge aclk);
			ab = arready && arvalid;
			rv = rvalid;
			d = rdata;
			r = rresp;
			n++;
			tmo(n);
			@(posedge aclk);
			if (ab)
				arvalid <= 1'h0;
		end while (!rv);
		rready <= 1'h0;
	endtask
	// Polls the host until its serial job is over; d then holds the read byte
	task job(input logic [3:0] a, input logic [31:0] v);
		int n;
		axw(a, v);
		n = 0;
		do
		begin
			axr(A_STATUS);
			n++;
			tmo(n);
		end while (d[0] !== 1'h0);
	endtask
	task dwr(input logic [6:0] a, input logic [7:0] v);
		job(A_FRAME, {17'h0, a, v});
	endtask
	task drd(input logic [6:0] a);
		job(A_FRAME, {16'h0, 1'h1, a, 8'h0});
	endtask
	task rdy;
		int n;
		n = 0;
		repeat (8) @(posedge aclk);
		do
		begin
			@(negedge aclk);
			n++;
			tmo(n);
		end while (link.conversion_ready_n !== 1'h1);
	endtask
	task por_is(input logic e);
		rdy();
		drd(ADDR_STATUS);
		chk(d[8], e);
		dwr(ADDR_STATUS, 8'h03);
	endtask
	task lat_meas(output int c);
		logic h;
		h = 1'h0;
		c = 0;
		axw(A_PINS, 32'h2);
		do
		begin
			@(negedge aclk);
			c++;
			tmo(c);
			h = h | link.conversion_ready_n;
		end while (!(h && !link.conversion_ready_n));
		chk({samp, filt}, 2'h3);
		axw(A_PINS, 32'h0);
	endtask
	initial
	begin
		void'($urandom(32'h30262c6e));
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		rdy();
		drd(ADDR_STATUS);
		chk(d[15:8], 8'h13);
		dwr(ADDR_STATUS, 8'h03);
		drd(ADDR_STATUS);
		chk(d[15:8], 8'h10);
		k = $urandom_range(3, 0);
		ana_ok[k[1:0]] <= 1'h0;
		repeat (4) @(posedge aclk);
		ana_ok[k[1:0]] <= 1'h1;
		drd(ADDR_STATUS);
		chk(d[15:8], 8'h12);
		dwr(ADDR_STATUS, 8'h02);
		drd(ADDR_STATUS);
		chk(d[15:8], 8'h10);
		dio_ok <= 1'h0;
		repeat (4) @(posedge aclk);
		dio_ok <= 1'h1;
		rdy();
		drd(ADDR_STATUS);
		chk(d[15:8], 8'h13);
		for (i = 0; i < 4; i++)
		begin
			k = $urandom_range(3, 0);
			dwr(ADDR_CFG_ONE, {7'h0, k[0]});
			dwr(ADDR_CFG_TWO, {7'h0, k[1]});
			chk({spd, cm}, k[1:0]);
			drd(ADDR_CFG_TWO);
			chk(d[15:8], {7'h0, k[1]});
		end
		dwr(ADDR_CFG_TWO, 8'h01);
		chk({samp, filt}, 2'h2);
		lat_meas(lat0);
		dwr(ADDR_CFG_TWO, 8'h03);
		chk({samp, filt}, 2'h0);
		lat_meas(lat1);
		chk(lat1 - lat0, STANDBY_EXTRA);
		dwr(ADDR_CFG_ONE, 8'h01);
		dwr(ADDR_CFG_TWO, 8'h05);
		chk({pwr, samp, filt}, 3'h0);
		drd(ADDR_CFG_ONE);
		chk(d[15:8], 8'h01);
		dwr(ADDR_CFG_TWO, 8'h01);
		chk(pwr, 1'h1);
		dwr(ADDR_CFG_TWO, 8'h05);
		dwr(ADDR_STATUS, 8'h03);
		axw(A_PINS, 32'h1);
		axw(A_PINS, 32'h0);
		por_is(1'h1);
		chk({pwr, cm}, 2'h2);
		k = $urandom_range(255, 0);
		if (k[7:0] == RESET_CODE)
			k = 32'h0;
		dwr(ADDR_CONTROL, k[7:0]);
		por_is(1'h0);
		dwr(ADDR_CONTROL, RESET_CODE);
		por_is(1'h1);
		dwr(ADDR_CFG_ONE, 8'h02);
		axw(A_PINS, 32'h4);
		dwr(ADDR_CONTROL, RESET_CODE);
		por_is(1'h1);
		axw(A_PINS, 32'h0);
		job(A_PATTERN, 32'h1);
		por_is(1'h1);
		job(A_PATTERN, 32'h0);
		por_is(1'h1);
		job(A_FRAME, 32'hffff);
		job(A_PATTERN, 32'h1);
		por_is(1'h1);
		axw(4'h2, 32'h0);
		chk(r, RESP_SLVERR);
		test_done();
	end
endmodule
